/* logic/wdrc_top.sv */
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "wdrc_regs.svh"
module wdrc_top #(
   parameter int OSC_DIV     = `WDRC_OSC_DIV,
   parameter int BASE_CYCLES = `WDRC_BASE_CYCLES
) (
   input  wire logic           clk,                  // 100 MHz clock
   input  wire logic           sys_rst,              // Power-on reset, async high
   input  wire wdrc_pkg::wdrc_byte_t reg_addr,       // Register address
   input  wire wdrc_pkg::wdrc_byte_t reg_wdata,      // Write data
   input  wire logic           reg_wr,               // Write strobe
   input  wire logic           reg_rd,               // Read strobe
   output wdrc_pkg::wdrc_byte_t reg_rdata,           // Read data, cycle after read
   input  wire logic           wdr_strobe,           // Restart instruction
   input  wire logic           global_int_enable,    // CPU global interrupt bit
   input  wire logic           vector_ack,           // Time-out vector executed
   input  wire logic           always_on_fuse,       // Fuse, 0 = programmed
   input  wire logic           ext_reset_evt,        // External pin reset
   input  wire logic           brownout_reset_evt,   // Brown-out reset
   input  wire logic           debug_port_reset_evt, // Test port reset
   output logic                timeout_irq,          // Interrupt request
   output logic                wdt_reset_pulse       // System reset request
);
   import wdrc_pkg::*;

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   logic [4:0]  cause_reg;
   logic        timeout_interrupt_flag_reg;
   logic        timeout_interrupt_enable_reg;
   logic        ce_reg;
   logic [2:0]  ce_cnt_reg;
   logic        wde_reg;
   wdrc_presc_t presc_reg;
   logic        irq_reg;
   logic        rst_pulse_reg;
   wdrc_byte_t  rdata_reg;

   logic        fuse_on;
   logic        cause_wr;
   logic        ctrl_wr;
   logic        sys_evt;
   logic        timeout;
   logic        rst_fire;
   logic        timeout_interrupt_flag_set;
   logic        ce_open;
   logic        wde_clear_ok;
   wdrc_mode_t  mode;
   logic [4:0]  cause_set;

   wdrc_cnt_if cnt_bus ();

   // ---------------------------------------------
   // Mode decode
   // ---------------------------------------------
   function automatic wdrc_mode_t wdrc_decode(
      input logic fuse,
      input logic system_reset_enable,
      input logic timeout_interrupt_enable
   );
      if (fuse) begin
         return wdrc_rst_only;
      end
      case ({system_reset_enable, timeout_interrupt_enable})
         2'h0:    return wdrc_stopped;
         2'h1:    return wdrc_irq_only;
         2'h2:    return wdrc_rst_only;
         2'h3:    return wdrc_irq_rst;
         default: return wdrc_stopped;
      endcase
   endfunction : wdrc_decode

   assign fuse_on  = !always_on_fuse;
   assign mode     = wdrc_decode(fuse_on, wde_reg, timeout_interrupt_enable_reg);
   assign cause_wr = reg_wr && (reg_addr == `WDRC_OFF_CAUSE);
   assign ctrl_wr  = reg_wr && (reg_addr == `WDRC_OFF_CTRL);
   assign timeout  = cnt_bus.timeout;

   // Any system reset returns the control register to its reset state, except WDE while the watchdog reset flag or the fuse forces it set
   assign sys_evt = ext_reset_evt || brownout_reset_evt
                    || debug_port_reset_evt || rst_pulse_reg;

   // ---------------------------------------------
   // Time-out actions
   // ---------------------------------------------
   assign rst_fire = timeout && ((mode == wdrc_rst_only)
                     || ((mode == wdrc_irq_rst) && timeout_interrupt_flag_reg));
   assign timeout_interrupt_flag_set = timeout && ((mode == wdrc_irq_only)
                     || ((mode == wdrc_irq_rst) && !timeout_interrupt_flag_reg));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rst_pulse_reg <= 1'b0;
      end else begin
         rst_pulse_reg <= rst_fire;
      end
   end

   // ---------------------------------------------
   // Counter link
   // ---------------------------------------------
   assign cnt_bus.run     = (mode != wdrc_stopped);
   assign cnt_bus.restart = wdr_strobe || sys_evt;
   assign cnt_bus.presc   = presc_reg;

   wdrc_counter #(
      .OSC_DIV     (OSC_DIV),
      .BASE_CYCLES (BASE_CYCLES)
   ) u_counter (
      .clk     (clk),
      .sys_rst (sys_rst),
      .link    (cnt_bus)
   );

   // ---------------------------------------------
   // Reset-cause flags
   // ---------------------------------------------
   assign cause_set = {debug_port_reset_evt, rst_fire, brownout_reset_evt,
                       ext_reset_evt, 1'b0};

   // Set wins over a software clear in the same cycle
   for (genvar i = 0; i < 5; i++) begin : g_cause
      logic flag_reg;

      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            flag_reg <= 1'(`WDRC_CAUSE_RST >> i);
         end else if (cause_set[i]) begin
            flag_reg <= 1'b1;
         end else if (cause_wr && !reg_wdata[i]) begin
            flag_reg <= 1'b0;
         end
      end

      assign cause_reg[i] = flag_reg;
   end

   // ---------------------------------------------
   // Change-enable window
   // ---------------------------------------------
   assign ce_open = ctrl_wr && reg_wdata[`WDRC_BIT_CE]
                    && reg_wdata[`WDRC_BIT_WDE];

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ce_reg     <= 1'b0;
         ce_cnt_reg <= 3'h0;
      end else if (sys_evt) begin
         ce_reg     <= 1'b0;
         ce_cnt_reg <= 3'h0;
      end else if (ctrl_wr) begin
         ce_reg     <= ce_open;
         ce_cnt_reg <= ce_open ? `WDRC_CE_WINDOW : 3'h0;
      end else if (ce_reg) begin
         ce_cnt_reg <= ce_cnt_reg - 3'h1;
         if (ce_cnt_reg == 3'h1) begin
            ce_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // Reset enable and prescaler
   // ---------------------------------------------
   assign wde_clear_ok = ce_reg && !cause_reg[`WDRC_BIT_WATCHDOG_RESET_FLAG] && !fuse_on;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wde_reg <= 1'b0;
      end else if (cause_reg[`WDRC_BIT_WATCHDOG_RESET_FLAG] || fuse_on) begin
         wde_reg <= 1'b1;
      end else if (sys_evt) begin
         wde_reg <= 1'b0;
      end else if (ctrl_wr) begin
         if (reg_wdata[`WDRC_BIT_WDE]) begin
            wde_reg <= 1'b1;
         end else if (wde_clear_ok) begin
            wde_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         presc_reg <= `WDRC_PRESC_RST;
      end else if (sys_evt) begin
         presc_reg <= `WDRC_PRESC_RST;
      end else if (ctrl_wr && ce_reg) begin
         presc_reg <= {reg_wdata[`WDRC_BIT_PS3], reg_wdata[2:0]};
      end
   end

   // ---------------------------------------------
   // Interrupt enable and flag
   // ---------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         timeout_interrupt_enable_reg <= 1'b0;
      end else if (fuse_on || sys_evt) begin
         timeout_interrupt_enable_reg <= 1'b0;
      end else if (vector_ack && (mode == wdrc_irq_rst)) begin
         timeout_interrupt_enable_reg <= 1'b0;
      end else if (ctrl_wr) begin
         timeout_interrupt_enable_reg <= reg_wdata[`WDRC_BIT_TIMEOUT_INTERRUPT_ENABLE];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         timeout_interrupt_flag_reg <= 1'b0;
      end else if (sys_evt) begin
         timeout_interrupt_flag_reg <= 1'b0;
      end else if (timeout_interrupt_flag_set) begin
         timeout_interrupt_flag_reg <= 1'b1;
      end else if (vector_ack || (ctrl_wr && reg_wdata[`WDRC_BIT_TIMEOUT_INTERRUPT_FLAG])) begin
         timeout_interrupt_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= global_int_enable && timeout_interrupt_enable_reg && timeout_interrupt_flag_reg;
      end
   end

   // ---------------------------------------------
   // Register read
   // ---------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `WDRC_OFF_CAUSE: rdata_reg <= {3'h0, cause_reg};
            `WDRC_OFF_CTRL:  rdata_reg <= {timeout_interrupt_flag_reg, timeout_interrupt_enable_reg, presc_reg[3], ce_reg,
                                           wde_reg, presc_reg[2:0]};
            default:         rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign reg_rdata       = rdata_reg;
   assign timeout_irq     = irq_reg;
   assign wdt_reset_pulse = rst_pulse_reg;

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_ce_opened;
      ce_open && !sys_evt;
   endsequence

   sequence s_quiet4;
      (!ctrl_wr && !sys_evt)[*4];
   endsequence

   AST_CE_OPENS: assert property (
      s_ce_opened |=> ce_reg && (ce_cnt_reg == 3'h4))
      else $error("change window did not open");

   AST_CE_CLOSES: assert property (
      s_ce_opened ##1 s_quiet4 |=> !ce_reg && $past(ce_reg))
      else $error("change window not four cycles");

   AST_PRESC_LOCK: assert property (
      ctrl_wr && !ce_reg && !sys_evt |=> $stable(presc_reg))
      else $error("prescale changed outside window");

   AST_WDE_FORCED: assert property (
      cause_reg[`WDRC_BIT_WATCHDOG_RESET_FLAG] && $past(cause_reg[`WDRC_BIT_WATCHDOG_RESET_FLAG]) |-> wde_reg)
      else $error("reset enable not forced by flag");

   AST_FUSE_LOCK: assert property (
      !always_on_fuse && $past(!always_on_fuse) |-> wde_reg && !timeout_interrupt_enable_reg)
      else $error("fuse lock not applied");

   AST_IRQ_GATE: assert property (
      !(global_int_enable && timeout_interrupt_enable_reg && timeout_interrupt_flag_reg) |=> !timeout_irq)
      else $error("interrupt without all enables");

   sequence s_first_to;
      timeout && (mode == wdrc_irq_rst) && !timeout_interrupt_flag_reg && !sys_evt;
   endsequence

   AST_FIRST_TIMEOUT: assert property (
      s_first_to |=> timeout_interrupt_flag_reg && !wdt_reset_pulse)
      else $error("first combined time-out wrong");

   AST_SECOND_TIMEOUT: assert property (
      timeout && (mode == wdrc_irq_rst) && timeout_interrupt_flag_reg
      |=> wdt_reset_pulse && cause_reg[`WDRC_BIT_WATCHDOG_RESET_FLAG])
      else $error("second time-out gave no reset");

   AST_VECTOR_CLEAR: assert property (
      vector_ack && (mode == wdrc_irq_rst) && !timeout |=> !timeout_interrupt_enable_reg && !timeout_interrupt_flag_reg)
      else $error("vector did not leave combined mode");

   AST_POR_KEEP: assert property (
      (ext_reset_evt || brownout_reset_evt) && !cause_wr
      |=> cause_reg[`WDRC_BIT_POWER_ON_FLAG] == $past(cause_reg[`WDRC_BIT_POWER_ON_FLAG]))
      else $error("power-on flag lost on reset");

   AST_EXT_FLAG: assert property (
      ext_reset_evt |=> cause_reg[`WDRC_BIT_EXTERNAL_RESET_FLAG])
      else $error("external flag not set");

   AST_READ_CAUSE: assert property (
      reg_rd && (reg_addr == `WDRC_OFF_CAUSE) |=> reg_rdata == {3'h0, $past(cause_reg)})
      else $error("cause read mismatch");

   AST_DBG_FLAG: assert property (
      debug_port_reset_evt |=> cause_reg[`WDRC_BIT_DBGRF])
      else $error("debug port flag not set");

   AST_BOR_FLAG: assert property (
      brownout_reset_evt |=> cause_reg[`WDRC_BIT_BROWNOUT_RESET_FLAG])
      else $error("brown-out flag not set");

   AST_RST_MODE: assert property (
      timeout && (mode == wdrc_rst_only) |=> wdt_reset_pulse && cause_reg[`WDRC_BIT_WATCHDOG_RESET_FLAG])
      else $error("reset mode time-out gave no reset");

endmodule : wdrc_top

/* logic/wdrc_regs.svh */
`ifndef WDRC_REGS_SVH
`define WDRC_REGS_SVH

// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define WDRC_OFF_CAUSE     8'h00
`define WDRC_OFF_CTRL      8'h01

// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define WDRC_BIT_DBGRF     4
`define WDRC_BIT_WATCHDOG_RESET_FLAG      3
`define WDRC_BIT_BROWNOUT_RESET_FLAG      2
`define WDRC_BIT_EXTERNAL_RESET_FLAG     1
`define WDRC_BIT_POWER_ON_FLAG      0
`define WDRC_BIT_TIMEOUT_INTERRUPT_FLAG      7
`define WDRC_BIT_TIMEOUT_INTERRUPT_ENABLE      6
`define WDRC_BIT_PS3       5
`define WDRC_BIT_CE        4
`define WDRC_BIT_WDE       3

// ---------------------------------------------
// Reset values
// ---------------------------------------------
`define WDRC_CAUSE_RST     5'h01
`define WDRC_PRESC_RST     4'h0
`define WDRC_PRESC_MAX     4'h9

// ---------------------------------------------
// Timing
// ---------------------------------------------
`define WDRC_CE_WINDOW     3'h4
`define WDRC_CLK_KHZ       100000
`define WDRC_OSC_KHZ       128
`define WDRC_OSC_DIV       (`WDRC_CLK_KHZ / `WDRC_OSC_KHZ)
`define WDRC_BASE_CYCLES   2048

`endif

/* logic/wdrc_pkg.sv */
package wdrc_pkg;

   // ---------------------------------------------
   // Types
   // ---------------------------------------------
   typedef enum logic [1:0] {
      wdrc_stopped,
      wdrc_irq_only,
      wdrc_rst_only,
      wdrc_irq_rst
   } wdrc_mode_t;

   typedef logic [3:0] wdrc_presc_t;
   typedef logic [7:0] wdrc_byte_t;

endpackage : wdrc_pkg

/* logic/wdrc_cnt_if.sv */
`timescale 1ns/10ps
interface wdrc_cnt_if;
   logic                 run;      // Counter enabled
   logic                 restart;  // Counter back to zero
   wdrc_pkg::wdrc_presc_t presc;   // Time-out select
   logic                 timeout;  // One-cycle time-out pulse

   modport ctl (output run, output restart, output presc, input timeout);
   modport cnt (input run, input restart, input presc, output timeout);
endinterface : wdrc_cnt_if

/* logic/wdrc_counter.sv */
`timescale 1ns/10ps
`include "wdrc_regs.svh"
module wdrc_counter #(
   parameter int OSC_DIV     = `WDRC_OSC_DIV,
   parameter int BASE_CYCLES = `WDRC_BASE_CYCLES
) (
   input wire logic clk,      // System clock
   input wire logic sys_rst,  // Async reset, high
   wdrc_cnt_if.cnt  link      // Control side
);
   import wdrc_pkg::*;

   localparam int DW = $clog2(OSC_DIV);
   localparam int CW = $clog2(BASE_CYCLES) + 10;

   logic [DW-1:0] div_reg;
   logic [CW-1:0] cnt_reg;
   logic          timeout_reg;
   logic          tick;
   logic [CW-1:0] limit;

   function automatic logic [CW-1:0] wdrc_limit(input wdrc_presc_t p);
      wdrc_presc_t s;
      s = (p > `WDRC_PRESC_MAX) ? `WDRC_PRESC_MAX : p;
      return (CW'(BASE_CYCLES) << s) - 1'b1;
   endfunction : wdrc_limit

   // ---------------------------------------------
   // Oscillator enable and counter
   // ---------------------------------------------
   // Oscillator rate as an enable on the one clock, so nothing crosses
   assign tick  = (div_reg == DW'(OSC_DIV - 1));
   assign limit = wdrc_limit(link.presc);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_reg <= '0;
      end else if (!link.run || link.restart || tick) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= '0;
      end else if (!link.run || link.restart) begin
         cnt_reg <= '0;
      end else if (tick) begin
         cnt_reg <= (cnt_reg == limit) ? '0 : cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         timeout_reg <= 1'b0;
      end else begin
         timeout_reg <= link.run && !link.restart && tick && (cnt_reg == limit);
      end
   end

   assign link.timeout = timeout_reg;

   AST_CNT_RESTART: assert property (
      @(posedge clk) disable iff (sys_rst)
      link.restart |=> (cnt_reg == '0) && !timeout_reg)
      else $error("counter not restarted");

   AST_CNT_LIMIT: assert property (
      @(posedge clk) disable iff (sys_rst)
      timeout_reg |-> $past(cnt_reg) == wdrc_limit($past(link.presc)))
      else $error("time-out at wrong count");

endmodule : wdrc_counter

/* tb/wdrc_cpu_model.sv */
`timescale 1ns/10ps
module wdrc_cpu_model (
   input  wire logic       clk,        // System clock
   input  wire logic       sys_rst,    // Async reset, high
   input  wire logic       irq,        // Time-out request
   input  wire logic       svc_en,     // Core takes interrupts
   input  wire logic [3:0] svc_delay,  // Cycles before vector runs
   output logic            vector_ack  // Vector executed pulse
);
   initial vector_ack = 1'b0;

   // ---------------------------------------------
   // Vector service
   // ---------------------------------------------
   // Vector runs only on a pending request, then waits three cycles before sampling it again
   always begin
      @(posedge clk);
      if (!sys_rst && svc_en && irq === 1'b1) begin
         repeat (svc_delay) @(posedge clk);
         vector_ack <= 1'b1;
         @(posedge clk);
         vector_ack <= 1'b0;
         repeat (3) @(posedge clk);
      end
   end
endmodule : wdrc_cpu_model

/* tb/wdrc_tb.sv */
`timescale 1ns/10ps
`include "wdrc_regs.svh"
module testbench;
   import wdrc_pkg::*;
   localparam int DIV = 2;
   localparam int BASE = 32;
   localparam int T0 = DIV * BASE;
   localparam wdrc_byte_t CA = `WDRC_OFF_CAUSE;
   localparam wdrc_byte_t CT = `WDRC_OFF_CTRL;
   typedef struct {string nm; wdrc_byte_t e;} wdrc_note_t;

   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   wdrc_byte_t reg_addr = 8'h00;
   wdrc_byte_t reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   wdrc_byte_t reg_rdata;
   logic       wdr_strobe = 1'b0;
   logic       gie = 1'b0;
   logic       vector_ack;
   logic       fuse = 1'b1;
   logic [2:0] evt = 3'h0;
   logic       timeout_irq;
   logic       wdt_reset_pulse;
   logic       svc_en = 1'b0;
   logic [3:0] svc_delay = 4'h1;
   logic       rd_d = 1'b0;
   int         rst_cnt = 0;
   int         error_cnt = 0;
   int         num_checks = 0;
   wdrc_note_t exp_q[$];
   wdrc_note_t cur;
   wdrc_byte_t lf = 8'h30;
   wdrc_byte_t cexp;
   int         c;

   always #5 clk = ~clk;

   wdrc_top #(.OSC_DIV(DIV), .BASE_CYCLES(BASE)) DUT (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdr_strobe(wdr_strobe),
      .global_int_enable(gie), .vector_ack(vector_ack), .always_on_fuse(fuse),
      .ext_reset_evt(evt[0]), .brownout_reset_evt(evt[1]),
      .debug_port_reset_evt(evt[2]), .timeout_irq(timeout_irq),
      .wdt_reset_pulse(wdt_reset_pulse));

   wdrc_cpu_model cpu (
      .clk(clk), .sys_rst(sys_rst), .irq(timeout_irq), .svc_en(svc_en),
      .svc_delay(svc_delay), .vector_ack(vector_ack));

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic chk(input string nm, input wdrc_byte_t seen, input wdrc_byte_t e);
      num_checks++;
      if (seen !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, seen);
      end
   endtask : chk

   function automatic wdrc_byte_t lfsr_next(input wdrc_byte_t v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr_next

   task automatic wr(input wdrc_byte_t a, input wdrc_byte_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input wdrc_byte_t a, input wdrc_byte_t e, input string nm);
      @(posedge clk);
      exp_q.push_back('{nm, e});
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd

   task automatic restart;
      @(posedge clk);
      wdr_strobe <= 1'b1;
      @(posedge clk);
      wdr_strobe <= 1'b0;
   endtask : restart

   // Software turns the watchdog off: flag clear, then the timed pair
   task automatic wd_off;
      wr(CA, 8'h00);
      restart();
      wr(CT, 8'h18);
      wr(CT, 8'h00);
   endtask : wd_off

   task automatic period(input int n, input string nm);
      int k;
      int c0;
      restart();
      c0 = rst_cnt;
      k = 0;
      while (rst_cnt == c0 && k < 20000) begin
         @(posedge clk);
         k++;
      end
      chk(nm, 8'((k >= n - 2) && (k <= n + 4)), 8'h01);
   endtask : period

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   // ---------------------------------------------
   // Monitor
   // ---------------------------------------------
   always @(posedge clk) begin
      if (rd_d) begin
         if (exp_q.size() == 0) begin
            chk("spare_read", 8'h01, 8'h00);
         end else begin
            cur = exp_q.pop_front();
            chk(cur.nm, reg_rdata, cur.e);
         end
      end
      rd_d <= reg_rd;
      if (wdt_reset_pulse === 1'b1) begin
         rst_cnt <= rst_cnt + 1;
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      stop_test();
   end

   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      rd(CA, 8'h01, "cause_rst");
      rd(CT, 8'h00, "ctrl_rst");
      rd(8'h05, 8'h00, "unmapped");
      $display("test reset done");
      cexp = 8'h01;
      for (int i = 0; i < 4; i++) begin
         lf = lfsr_next(lf);
         @(posedge clk);
         evt <= (i == 0) ? 3'h7 : lf[2:0];
         @(posedge clk);
         evt <= 3'h0;
         cexp = cexp | {3'h0, evt[2], 1'b0, evt[1], evt[0], 1'b0};
         rd(CA, cexp, "cause_set");
         wr(CA, lf);
         cexp = cexp & lf & 8'h1f;
         rd(CA, cexp, "cause_wr0");
      end
      wr(CA, 8'h00);
      $display("test cause done");
      restart();
      wr(CT, 8'h40);
      repeat (T0 + 8) @(posedge clk);
      rd(CT, 8'hc0, "int_flag");
      chk("irq_masked", 8'(timeout_irq), 8'h00);
      gie <= 1'b1;
      repeat (3) @(posedge clk);
      chk("irq_on", 8'(timeout_irq), 8'h01);
      svc_en <= 1'b1;
      repeat (8) @(posedge clk);
      chk("irq_off", 8'(timeout_irq), 8'h00);
      rd(CT, 8'h40, "vec_clr");
      svc_en <= 1'b0;
      gie <= 1'b0;
      repeat (T0) @(posedge clk);
      wr(CT, 8'hc0);
      rd(CT, 8'h40, "w1c");
      $display("test interrupt done");
      restart();
      wr(CT, 8'h48);
      c = rst_cnt;
      repeat (T0 + 8) @(posedge clk);
      rd(CT, 8'hc8, "comb_first");
      chk("comb_norst", 8'(rst_cnt - c), 8'h00);
      repeat (T0) @(posedge clk);
      chk("comb_rst", 8'(rst_cnt - c), 8'h01);
      rd(CA, 8'h08, "wd_flag");
      wr(CT, 8'h18);
      wr(CT, 8'h00);
      rd(CT, 8'h08, "wde_forced");
      wd_off();
      rd(CT, 8'h00, "wde_off");
      restart();
      wr(CT, 8'h48);
      gie <= 1'b1;
      svc_en <= 1'b1;
      svc_delay <= 4'h4;
      repeat (T0 + 12) @(posedge clk);
      rd(CT, 8'h08, "comb_svc");
      svc_en <= 1'b0;
      gie <= 1'b0;
      wd_off();
      $display("test combined done");
      restart();
      wr(CT, 8'h09);
      rd(CT, 8'h08, "ps_locked");
      period(T0, "period_p0");
      restart();
      wr(CT, 8'h18);
      wr(CT, 8'h09);
      rd(CT, 8'h09, "ps_set");
      period(2 * T0, "period_p1");
      wr(CA, 8'h00);
      restart();
      wr(CT, 8'h18);
      rd(CT, 8'h18, "ce_open");
      repeat (4) @(posedge clk);
      rd(CT, 8'h08, "ce_closed");
      wr(CT, 8'h00);
      rd(CT, 8'h08, "late_clr");
      wd_off();
      c = rst_cnt;
      repeat (3 * T0) @(posedge clk);
      chk("stopped", 8'(rst_cnt - c), 8'h00);
      $display("test prescale done");
      fuse <= 1'b0;
      repeat (2) @(posedge clk);
      wr(CT, 8'h40);
      rd(CT, 8'h08, "fuse_lock");
      period(T0, "fuse_rst");
      fuse <= 1'b1;
      repeat (4) @(posedge clk);
      $display("test fuse done");
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      rd(CA, 8'h01, "por_cause");
      rd(CT, 8'h00, "por_ctrl");
      $display("test power-on done");
      stop_test();
   end
endmodule : testbench
